// ### rtl/cmt_pkg.sv
// Package for the capture/match timer: register offsets, field positions,
// reset values and the bus request carrier struct.
// Assumes a plain synchronous register port with one-cycle read latency.
package cmt_pkg;
	// Register offsets (byte addresses, one word each)
	localparam logic [7:0] CMT_OFS_CTRL   = 8'h00; // Enable, mode, counter reset
	localparam logic [7:0] CMT_OFS_PRE    = 8'h04; // Prescale limit
	localparam logic [7:0] CMT_OFS_PCNT   = 8'h08; // Prescale count, read only
	localparam logic [7:0] CMT_OFS_CNT    = 8'h0c; // Counter value, read only
	localparam logic [7:0] CMT_OFS_MCTL   = 8'h10; // Match control
	localparam logic [7:0] CMT_OFS_CAPCTL = 8'h14; // Capture control
	localparam logic [7:0] CMT_OFS_CAP    = 8'h18; // Capture value, read only
	localparam logic [7:0] CMT_OFS_EMR    = 8'h1c; // External match control/state
	localparam logic [7:0] CMT_OFS_STAT   = 8'h20; // Sticky event status, W1C
	localparam logic [7:0] CMT_OFS_MASK   = 8'h24; // Interrupt mask
	localparam logic [7:0] CMT_OFS_MAT0   = 8'h30; // Match 0, next ones step by 4
	// Control fields
	localparam int CMT_CTRL_EN    = 0; // Count enable
	localparam int CMT_CTRL_CRST  = 1; // Hold counter and prescaler in reset
	localparam int CMT_CTRL_MODE  = 2; // 0 timer, 1 counter of input edges
	localparam int CMT_CTRL_CEDGE = 3; // Counter mode edge: 0 rising, 1 falling
	// Match control: per channel three bits, interrupt/reset/stop
	localparam int CMT_MCTL_INT  = 0;
	localparam int CMT_MCTL_RST  = 1;
	localparam int CMT_MCTL_STOP = 2;
	localparam int CMT_MCTL_W    = 3;
	// Capture control fields
	localparam int CMT_CAP_RISE  = 0; // Capture on rising edge
	localparam int CMT_CAP_FALL  = 1; // Capture on falling edge
	localparam int CMT_CAP_CLRR  = 2; // Clear count on rising edge
	localparam int CMT_CAP_CLRF  = 3; // Clear count on falling edge
	// External match: bits 3:0 state, bits 11:4 two-bit action per output
	localparam int CMT_EMR_ACT   = 4;
	// Status bits: 3:0 matches, 4 capture
	localparam int CMT_ST_CAP    = 4;
	localparam int CMT_NEV       = 5;
	// Pin actions
	localparam logic [1:0] CMT_ACT_NONE = 2'h0;
	localparam logic [1:0] CMT_ACT_LOW  = 2'h1;
	localparam logic [1:0] CMT_ACT_HIGH = 2'h2;
	localparam logic [1:0] CMT_ACT_TOG  = 2'h3;
	// Reset values
	localparam logic [31:0] CMT_RST_ZERO = 32'h0000_0000;
	// Register bus request carrier
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} cmt_bus_req_t;
endpackage

// ### rtl/cmt_match_ch.sv
// One match channel: compare, external pin action and event pulse.
// Assumes the caller gives a one-cycle tick for each counter advance.
`timescale 1ns/1ps
module cmt_match_ch #(
	parameter int W = 32
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         sys_rst_i,
	input  wire logic         ce_i,
	// Compare inputs
	input  wire logic         tick_i,
	input  wire logic [W-1:0] count_i,
	input  wire logic [W-1:0] match_i,
	input  wire logic [1:0]   act_i,
	// Software write to the pin state
	input  wire logic         pin_wr_i,
	input  wire logic         pin_wd_i,
	// Results
	output logic              hit_o,
	output logic              pin_o
);
	import cmt_pkg::*;
	logic pin_reg; // Pin state
	logic pin_next; // Pin next value

	// Equality is checked on the counter tick so each value fires once
	assign hit_o = tick_i && (count_i == match_i);

	// Pin action selection on hit
	always_comb begin
		pin_next = pin_reg;
		if (hit_o) begin
			case (act_i)
				CMT_ACT_LOW:  pin_next = 1'b0;
				CMT_ACT_HIGH: pin_next = 1'b1;
				CMT_ACT_TOG:  pin_next = ~pin_reg;
				default:      pin_next = pin_reg;
			endcase
		end else if (pin_wr_i) begin
			pin_next = pin_wd_i;
		end
	end

	// Pin state flop
	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			pin_reg <= 1'b0;
		else if (ce_i)
			pin_reg <= pin_next;
	end
	assign pin_o = pin_reg;
endmodule

// ### rtl/cmt_timer.sv
// Capture/match timer top: prescaler, counter, four match channels,
// one capture channel, sticky status with mask and a level interrupt.
// Assumes inputs synchronous to clk_i; cap_i and cnt_in_i are clean levels.
`timescale 1ns/1ps
module cmt_timer #(
	parameter int W = 32
) (
	// Clock, reset, enable
	input  wire logic                  clk_i,
	input  wire logic                  sys_rst_i,
	input  wire logic                  ce_i,
	// Register port
	input  wire logic [7:0]            addr_i,
	input  wire logic [31:0]           wdata_i,
	input  wire logic                  wr_i,
	input  wire logic                  rd_i,
	output logic      [31:0]           rdata_o,
	// Pins
	input  wire logic                  cap_i,
	input  wire logic                  cnt_in_i,
	output logic      [3:0]            mat_o,
	// Interrupt
	output logic                       irq_o
);
	import cmt_pkg::*;

	cmt_bus_req_t         req;         // Bundled request
	logic [3:0]           ctrl_reg;    // Control bits
	logic [W-1:0]         pre_reg;     // Prescale limit
	logic [W-1:0]         pcnt_reg;    // Prescale count
	logic [W-1:0]         cnt_reg;     // Counter
	logic [11:0]          mctl_reg;    // Match control
	logic [3:0]           capc_reg;    // Capture control
	logic [W-1:0]         cap_reg;     // Capture value
	logic [7:0]           eact_reg;    // External pin actions
	logic [CMT_NEV-1:0]   stat_reg;    // Sticky status
	logic [CMT_NEV-1:0]   mask_reg;    // Interrupt mask
	logic [W-1:0]         mat_reg [4]; // Match values
	logic                 capd_reg;    // Capture input, last cycle
	logic                 cind_reg;    // Count input, last cycle
	logic [31:0]          rdata_reg;   // Read data
	logic                 irq_reg;     // Interrupt flop
	logic [3:0]           hit;         // Match hits this cycle
	logic [3:0]           pin;         // Match pin states

	assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

	// Write decodes
	wire wr_ctrl = req.wr && req.addr == CMT_OFS_CTRL;
	wire wr_pre  = req.wr && req.addr == CMT_OFS_PRE;
	wire wr_mctl = req.wr && req.addr == CMT_OFS_MCTL;
	wire wr_capc = req.wr && req.addr == CMT_OFS_CAPCTL;
	wire wr_emr  = req.wr && req.addr == CMT_OFS_EMR;
	wire wr_stat = req.wr && req.addr == CMT_OFS_STAT;
	wire wr_mask = req.wr && req.addr == CMT_OFS_MASK;

	// Input edges
	wire cap_rise = cap_i && !capd_reg;
	wire cap_fall = !cap_i && capd_reg;
	wire cin_edge = ctrl_reg[CMT_CTRL_CEDGE] ? (!cnt_in_i && cind_reg) : (cnt_in_i && !cind_reg);

	// Tick source: every clock in timer mode, each input edge in counter mode
	wire src_tick = ctrl_reg[CMT_CTRL_MODE] ? cin_edge : 1'b1;
	wire running  = ctrl_reg[CMT_CTRL_EN] && !ctrl_reg[CMT_CTRL_CRST];
	wire pre_wrap = running && src_tick && (pcnt_reg == pre_reg);

	// Capture and capture-clear events
	wire cap_ev = (capc_reg[CMT_CAP_RISE] && cap_rise) || (capc_reg[CMT_CAP_FALL] && cap_fall);
	wire clr_ev = (capc_reg[CMT_CAP_CLRR] && cap_rise) || (capc_reg[CMT_CAP_CLRF] && cap_fall);

	// Match control fan-out
	logic [3:0] m_rst;
	logic [3:0] m_stop;
	logic [3:0] m_int;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			m_int[i]  = mctl_reg[i*CMT_MCTL_W + CMT_MCTL_INT];
			m_rst[i]  = mctl_reg[i*CMT_MCTL_W + CMT_MCTL_RST];
			m_stop[i] = mctl_reg[i*CMT_MCTL_W + CMT_MCTL_STOP];
		end
	end
	wire any_rst  = |(hit & m_rst);
	wire any_stop = |(hit & m_stop);

	// Events; a match sets its status flag only if its interrupt bit is enabled
	wire [CMT_NEV-1:0] ev = {cap_ev, hit & m_int};

	// Match channels, each compares on the counter tick
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_m
			cmt_match_ch #(.W(W)) u_ch (
				.clk_i     (clk_i),
				.sys_rst_i (sys_rst_i),
				.ce_i      (ce_i),
				.tick_i    (pre_wrap),
				.count_i   (cnt_reg),
				.match_i   (mat_reg[g]),
				.act_i     (eact_reg[2*g +: 2]),
				.pin_wr_i  (wr_emr),
				.pin_wd_i  (req.wdata[g]),
				.hit_o     (hit[g]),
				.pin_o     (pin[g])
			);
		end
	endgenerate

	// Read mux; unmapped addresses read zero
	logic [31:0] rmux;
	always_comb begin
		rmux = 32'h0000_0000;
		case (req.addr)
			CMT_OFS_CTRL:   rmux = {28'h0, ctrl_reg};
			CMT_OFS_PRE:    rmux = 32'(pre_reg);
			CMT_OFS_PCNT:   rmux = 32'(pcnt_reg);
			CMT_OFS_CNT:    rmux = 32'(cnt_reg);
			CMT_OFS_MCTL:   rmux = {20'h0, mctl_reg};
			CMT_OFS_CAPCTL: rmux = {28'h0, capc_reg};
			CMT_OFS_CAP:    rmux = 32'(cap_reg);
			CMT_OFS_EMR:    rmux = {20'h0, eact_reg, pin};
			CMT_OFS_STAT:   rmux = {27'h0, stat_reg};
			CMT_OFS_MASK:   rmux = {27'h0, mask_reg};
			CMT_OFS_MAT0:   rmux = 32'(mat_reg[0]);
			CMT_OFS_MAT0 + 8'h04: rmux = 32'(mat_reg[1]);
			CMT_OFS_MAT0 + 8'h08: rmux = 32'(mat_reg[2]);
			CMT_OFS_MAT0 + 8'h0c: rmux = 32'(mat_reg[3]);
			default:        rmux = 32'h0000_0000;
		endcase
	end

	// Configuration registers; stop match drops the enable bit
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ctrl_reg <= 4'h0;
			pre_reg  <= '0;
			mctl_reg <= 12'h000;
			capc_reg <= 4'h0;
			eact_reg <= 8'h00;
			mask_reg <= '0;
		end else if (ce_i) begin
			if (wr_ctrl)
				ctrl_reg <= req.wdata[3:0];
			if (any_stop)
				ctrl_reg[CMT_CTRL_EN] <= 1'b0;
			if (wr_pre)
				pre_reg <= req.wdata[W-1:0];
			if (wr_mctl)
				mctl_reg <= req.wdata[11:0];
			if (wr_capc)
				capc_reg <= req.wdata[3:0];
			if (wr_emr)
				eact_reg <= req.wdata[CMT_EMR_ACT +: 8];
			if (wr_mask)
				mask_reg <= req.wdata[CMT_NEV-1:0];
		end
	end

	// Match value registers
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < 4; i++)
				mat_reg[i] <= '0;
		end else if (ce_i) begin
			for (int i = 0; i < 4; i++)
				if (req.wr && req.addr == CMT_OFS_MAT0 + 8'(4*i))
					mat_reg[i] <= req.wdata[W-1:0];
		end
	end

	// Prescaler and counter; capture clear wins over counting
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pcnt_reg <= '0;
			cnt_reg  <= '0;
		end else if (ce_i) begin
			if (ctrl_reg[CMT_CTRL_CRST] || clr_ev) begin
				pcnt_reg <= '0;
				cnt_reg  <= '0;
			end else if (running && src_tick) begin
				if (pre_wrap) begin
					pcnt_reg <= '0;
					cnt_reg  <= any_rst ? '0 : cnt_reg + 1'b1;
				end else begin
					pcnt_reg <= pcnt_reg + 1'b1;
				end
			end
		end
	end

	// Capture register and input history
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cap_reg  <= '0;
			capd_reg <= 1'b0;
			cind_reg <= 1'b0;
		end else if (ce_i) begin
			capd_reg <= cap_i;
			cind_reg <= cnt_in_i;
			if (cap_ev)
				cap_reg <= cnt_reg;
		end
	end

	// Sticky status; a new event wins over the write-one clear
	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			stat_reg <= '0;
		else if (ce_i)
			stat_reg <= (stat_reg & ~(wr_stat ? req.wdata[CMT_NEV-1:0] : '0)) | ev;
	end

	// Read data and interrupt output flops
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rdata_reg <= 32'h0000_0000;
			irq_reg   <= 1'b0;
			mat_o     <= 4'h0;
		end else if (ce_i) begin
			rdata_reg <= req.rd ? rmux : 32'h0000_0000;
			irq_reg   <= |(stat_reg & mask_reg);
			mat_o     <= pin;
		end
	end
	assign rdata_o = rdata_reg;
	assign irq_o   = irq_reg;

	// Stop match clears the enable bit on the next cycle
	property p_stop_halts;
		@(posedge clk_i) disable iff (sys_rst_i)
		(ce_i && any_stop && !wr_ctrl) |=> !ctrl_reg[CMT_CTRL_EN];
	endproperty
	a_stop_halts: assert property (p_stop_halts) else $error("stop match left enable set");

	// Reset match zeroes the counter
	property p_rst_zero;
		@(posedge clk_i) disable iff (sys_rst_i)
		(ce_i && any_rst && !clr_ev && !ctrl_reg[CMT_CTRL_CRST]) |=> cnt_reg == '0;
	endproperty
	a_rst_zero: assert property (p_rst_zero) else $error("reset match did not clear counter");

	// Capture copies the count
	property p_capture;
		@(posedge clk_i) disable iff (sys_rst_i)
		(ce_i && cap_ev) |=> cap_reg == $past(cnt_reg);
	endproperty
	a_capture: assert property (p_capture) else $error("capture value wrong");

	// Capture clear zeroes both counts
	property p_cap_clear;
		@(posedge clk_i) disable iff (sys_rst_i)
		(ce_i && clr_ev) |=> (cnt_reg == '0 && pcnt_reg == '0);
	endproperty
	a_cap_clear: assert property (p_cap_clear) else $error("capture clear failed");

	// Counter only moves on a prescaler wrap
	property p_adv;
		@(posedge clk_i) disable iff (sys_rst_i)
		(ce_i && !pre_wrap && !clr_ev && !ctrl_reg[CMT_CTRL_CRST]) |=> $stable(cnt_reg);
	endproperty
	a_adv: assert property (p_adv) else $error("counter moved without wrap");

	// Timer mode ticks each enabled cycle
	property p_timer_mode;
		@(posedge clk_i) disable iff (sys_rst_i)
		(ce_i && running && !ctrl_reg[CMT_CTRL_MODE] && !clr_ev && pcnt_reg != pre_reg)
			|=> pcnt_reg == $past(pcnt_reg) + 1'b1;
	endproperty
	a_timer_mode: assert property (p_timer_mode) else $error("prescaler did not advance");

	// Capture event sets its sticky flag on the next cycle
	property p_sticky;
		@(posedge clk_i) disable iff (sys_rst_i)
		(ce_i && ev[CMT_ST_CAP]) |=> stat_reg[CMT_ST_CAP];
	endproperty
	a_sticky: assert property (p_sticky) else $error("capture flag lost");

	// Unmasked status raises the interrupt one cycle on
	property p_irq;
		@(posedge clk_i) disable iff (sys_rst_i)
		(ce_i && |(stat_reg & mask_reg)) |=> irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not raised");

	// Match 1 set-high action shows on its pin two cycles later
	property p_pin_high;
		@(posedge clk_i) disable iff (sys_rst_i)
		(ce_i && hit[1] && eact_reg[3:2] == CMT_ACT_HIGH) ##1 ce_i |=> mat_o[1];
	endproperty
	a_pin_high: assert property (p_pin_high) else $error("match pin not high");

	// Match flag set on equal compare with interrupt enabled
	property p_match_flag;
		@(posedge clk_i) disable iff (sys_rst_i)
		(ce_i && pre_wrap && cnt_reg == mat_reg[1] && m_int[1]) |=> stat_reg[1];
	endproperty
	a_match_flag: assert property (p_match_flag) else $error("match flag not set");
endmodule

// ### test/cmt_pin_model.sv
// Pin-side partner of the timer: drives the capture and count inputs.
// Assumes the bench clock; tasks are called from one bench process only.
`timescale 1ns/1ps
module cmt_pin_model (
	// Clock
	input  wire logic       clk_i,
	// Pins toward the timer
	output logic            cap_o,
	output logic            cnt_o,
	input  wire logic [3:0] mat_i
);
	// Both inputs idle low as clean levels
	initial begin
		cap_o = 1'b0;
		cnt_o = 1'b0;
	end
	// Rising edges seen on match pin 0, read back by the bench
	logic mat0_d;     // Pin 0, last cycle
	int   mat0_rises; // Count of low-to-high changes
	always_ff @(posedge clk_i) begin
		mat0_d <= mat_i[0];
		if (mat_i[0] && !mat0_d)
			mat0_rises <= mat0_rises + 1;
	end
	// Rising edges on the count pin; hold sets the pace, slow or prompt
	task automatic count_edges(input int n, input int hold);
		repeat (n) begin
			@(posedge clk_i);
			cnt_o <= 1'b1;
			repeat (hold) @(posedge clk_i);
			cnt_o <= 1'b0;
			@(posedge clk_i);
		end
	endtask
	// One level change on the capture pin, then let it settle
	task automatic cap_level(input logic v);
		@(posedge clk_i);
		cap_o <= v;
		repeat (3) @(posedge clk_i);
	endtask
endmodule

// ### test/test_cmt_timer.sv
// Self-checking bench for the capture/match timer, 32-bit variant.
// Assumes the register map of cmt_pkg and the pin model beside it.
`timescale 1ns/1ps
module test_cmt_timer;
	import cmt_pkg::*;
	// Design connections
	logic        clk_i;
	logic        sys_rst_i;
	logic        ce_i;
	logic [7:0]  addr_i;
	logic [31:0] wdata_i;
	logic        wr_i;
	logic        rd_i;
	logic [31:0] rdata_o;
	logic        cap_i;
	logic        cnt_in_i;
	logic [3:0]  mat_o;
	logic        irq_o;
	// Bookkeeping
	int          err_count = 0;
	int          checks_done = 0;
	logic [31:0] snap;
	// Design under test
	cmt_timer #(.W(32)) u_cmt_timer (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .cap_i(cap_i), .cnt_in_i(cnt_in_i),
		.mat_o(mat_o), .irq_o(irq_o)
	);
	// Far side of the pins
	cmt_pin_model u_cmt_pin_model (
		.clk_i(clk_i), .cap_o(cap_i), .cnt_o(cnt_in_i), .mat_i(mat_o)
	);
	// 20 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		d = rdata_o;
	endtask
	// Register word compare
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Pin or interrupt level compare
	task automatic pchk(input logic [3:0] got, input logic [3:0] exp);
		chk({28'h0, got}, {28'h0, exp});
	endtask
	// Read then compare
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d);
		chk(d, exp);
	endtask
	// Single place where the run ends
	task automatic summarize();
		$display("checks %0d, mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		summarize();
	end
	// Main sequence
	initial begin
		sys_rst_i = 1'b1;
		ce_i      = 1'b1;
		addr_i    = 8'h00;
		wdata_i   = 32'h0000_0000;
		wr_i      = 1'b0;
		rd_i      = 1'b0;
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		// Reset state; the read-only count refuses writes, an unmapped place reads zero
		wr(CMT_OFS_CNT, 32'h0000_0055);
		rchk(CMT_OFS_CNT, 32'h0);
		rchk(8'h2c, 32'h0);
		rchk(CMT_OFS_STAT, 32'h0);
		pchk(mat_o, 4'h0);
		$display("test reset done");
		// Counter mode, prescaler limit 1: seven edges give count 3, rest 1
		wr(CMT_OFS_PRE, 32'h1);
		wr(CMT_OFS_CTRL, 32'h5);
		u_cmt_pin_model.count_edges(7, 2);
		rchk(CMT_OFS_CNT, 32'h3);
		rchk(CMT_OFS_PCNT, 32'h1);
		$display("test prescale done");
		// Capture on rise, sticky flag, mask gating the level interrupt
		wr(CMT_OFS_CAPCTL, 32'h1);
		u_cmt_pin_model.cap_level(1'b1);
		rchk(CMT_OFS_CAP, 32'h3);
		rchk(CMT_OFS_STAT, 32'h10);
		pchk({3'h0, irq_o}, 4'h0);
		wr(CMT_OFS_MASK, 32'h10);
		repeat (2) @(posedge clk_i);
		pchk({3'h0, irq_o}, 4'h1);
		wr(CMT_OFS_STAT, 32'h10);
		repeat (2) @(posedge clk_i);
		pchk({3'h0, irq_o}, 4'h0);
		rchk(CMT_OFS_STAT, 32'h0);
		$display("test capture done");
		// Clear on falling capture edge zeroes counter and prescaler
		wr(CMT_OFS_CAPCTL, 32'h8);
		u_cmt_pin_model.cap_level(1'b0);
		rchk(CMT_OFS_CNT, 32'h0);
		rchk(CMT_OFS_PCNT, 32'h0);
		$display("test capture clear done");
		// Pulse width: clear on lead, capture on trail
		wr(CMT_OFS_CAPCTL, 32'h6);
		wr(CMT_OFS_PRE, 32'h0);
		u_cmt_pin_model.count_edges(2, 1);
		u_cmt_pin_model.cap_level(1'b1);
		u_cmt_pin_model.count_edges(5, 1);
		u_cmt_pin_model.cap_level(1'b0);
		rchk(CMT_OFS_CAP, 32'h5);
		wr(CMT_OFS_STAT, 32'h1f);
		$display("test pulse width done");
		// Matches: 0 toggles, 1 resets and sets high, 2 low, 3 does nothing
		wr(CMT_OFS_CTRL, 32'h6);
		wr(CMT_OFS_MAT0, 32'h1);
		wr(CMT_OFS_MAT0 + 8'h04, 32'h2);
		wr(CMT_OFS_MAT0 + 8'h08, 32'h1);
		wr(CMT_OFS_MAT0 + 8'h0c, 32'h1);
		wr(CMT_OFS_MCTL, 32'h19);
		wr(CMT_OFS_EMR, 32'h1bc);
		wr(CMT_OFS_CTRL, 32'h5);
		pchk(mat_o, 4'hc);
		u_cmt_pin_model.count_edges(3, 1);
		rchk(CMT_OFS_CNT, 32'h0);
		rchk(CMT_OFS_STAT, 32'h3);
		pchk(mat_o, 4'hb);
		u_cmt_pin_model.count_edges(2, 1);
		rchk(CMT_OFS_CNT, 32'h2);
		pchk(mat_o, 4'ha);
		chk(u_cmt_pin_model.mat0_rises, 32'h1);
		wr(CMT_OFS_STAT, 32'h1);
		rchk(CMT_OFS_STAT, 32'h2);
		$display("test match done");
		// Timer mode, stop on match 0 halts the count and drops enable
		wr(CMT_OFS_CTRL, 32'h2);
		wr(CMT_OFS_MCTL, 32'h5);
		wr(CMT_OFS_MAT0, 32'h9);
		wr(CMT_OFS_STAT, 32'h1f);
		wr(CMT_OFS_CTRL, 32'h1);
		repeat (30) @(posedge clk_i);
		rd(CMT_OFS_CNT, snap);
		// The hit cycle still steps, so the count rests one past the match
		chk(snap, 32'h0000_000a);
		repeat (5) @(posedge clk_i);
		rchk(CMT_OFS_CNT, snap);
		rchk(CMT_OFS_CTRL, 32'h0);
		rchk(CMT_OFS_STAT, 32'h1);
		$display("test stop done");
		// Clock enable low freezes the running counter at its stop value
		wr(CMT_OFS_CTRL, 32'h1);
		ce_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		ce_i <= 1'b1;
		rchk(CMT_OFS_CNT, 32'hb);
		$display("test clock enable done");
		summarize();
	end
endmodule
